//--- hdl/cies_core.v
// Instruction execution core subset with APB register access
// Behaviour
// RULE1: watchdog clear zeroes counter, prescaler; sets flags
// RULE2: call pushes program counter plus one
// RULE3: call loads target and two latch bits
// RULE4: call takes two cycles, flags untouched
// RULE5: complement register, route by destination, zero
// RULE6: clear register writes zero, sets zero
// RULE7: clear accumulator writes zero, sets zero
// RULE8: decrement register, route by destination, zero
// RULE9: decrement-skip routes result, flags untouched
// RULE10: zero result replaces next instruction with nop
// RULE11: zero flag set exactly when result zero
// RULE12: taken skip lasts two cycles via nop
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "cies_consts.vh"

module cies_core (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr
);

  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_EXEC  = 2'd1;
  localparam [1:0] ST_FLUSH = 2'd2;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [13:0] instr_r;
  reg  [7:0]  accum_r;
  reg  [7:0]  accum_nxt;
  reg  [12:0] pc_r;
  reg  [12:0] pc_nxt;
  reg  [4:0]  pc_high_latch_r;
  reg  [6:0]  file_addr_r;
  reg         zero_r;
  reg         zero_nxt;
  reg         timeout_flag_r;
  reg         powerdown_flag_r;
  reg         skip_r;
  reg         skip_nxt;
  reg  [7:0]  prescale_r;
  reg  [7:0]  watchdog_counter_r;
  reg  [12:0] stack_mem [0:`CIES_STACK_DEPTH-1];
  reg  [2:0]  sp_r;
  reg         push_nxt;
  reg         wdog_clr;
  reg         core_we;
  reg  [7:0]  core_wdata;
  reg  [31:0] rd_mux;

  wire        busy;
  wire        apb_acc;
  wire        apb_wr;
  wire        addr_ok;
  wire [6:0]  core_faddr;
  wire [7:0]  file_rdata;
  wire [7:0]  dec_val;
  wire [7:0]  inv_val;
  wire        dest_file;
  wire [12:0] pc_plus1;
  wire [12:0] stack_top;
  wire        rf_we;
  wire [6:0]  rf_waddr;
  wire [7:0]  rf_wdata;
  wire [6:0]  rf_raddr;
  wire        presc_tick;

  assign busy      = (state_r != ST_IDLE);
  assign apb_acc   = psel & penable;
  // Writes wait while an instruction is in flight so software never races the core
  assign pready    = ~(apb_acc & pwrite & busy);
  assign apb_wr    = apb_acc & pwrite & pready & addr_ok;
  assign addr_ok   = (paddr == `CIES_ADDR_INSTR) | (paddr == `CIES_ADDR_ACCUM) |
                     (paddr == `CIES_ADDR_STATUS) | (paddr == `CIES_ADDR_PC) |
                     (paddr == `CIES_ADDR_PC_LATCH) | (paddr == `CIES_ADDR_STACK_TOP) |
                     (paddr == `CIES_ADDR_WDOG) | (paddr == `CIES_ADDR_FILE_ADDR) |
                     (paddr == `CIES_ADDR_FILE_DATA);
  assign pslverr   = apb_acc & pready & ~addr_ok;

  assign core_faddr = instr_r[6:0];
  assign dest_file  = instr_r[`CIES_DEST_BIT];
  assign dec_val    = file_rdata - 8'h01;
  assign inv_val    = ~file_rdata;
  assign pc_plus1   = pc_r + 13'h0001;
  assign stack_top  = stack_mem[sp_r - 3'd1];

  // Core owns the file port while busy, software only while idle
  assign rf_we    = busy ? core_we : (apb_wr & (paddr == `CIES_ADDR_FILE_DATA));
  assign rf_waddr = busy ? core_faddr : file_addr_r;
  assign rf_wdata = busy ? core_wdata : pwdata[7:0];
  assign rf_raddr = busy ? core_faddr : file_addr_r;

  cies_regfile u_regfile (
    .pclk  (pclk),
    .we    (rf_we),
    .waddr (rf_waddr),
    .wdata (rf_wdata),
    .raddr (rf_raddr),
    .rdata (file_rdata)
  );

  // Execute stage decode
  always @* begin
    state_nxt  = state_r;
    accum_nxt  = accum_r;
    pc_nxt     = pc_r;
    zero_nxt   = zero_r;
    skip_nxt   = 1'b0;
    push_nxt   = 1'b0;
    wdog_clr   = 1'b0;
    core_we    = 1'b0;
    core_wdata = 8'h00;
    case (state_r)
      ST_EXEC: begin
        state_nxt = ST_IDLE;
        pc_nxt    = pc_plus1;
        if (instr_r == `CIES_OP_WDOG_CLR) begin
          wdog_clr = 1'b1; // RULE1
        end else if ((instr_r & `CIES_OP_CALL_MASK) == `CIES_OP_CALL_VAL) begin
          push_nxt  = 1'b1; // RULE2
          pc_nxt    = {pc_high_latch_r[4:3], instr_r[10:0]}; // RULE3
          state_nxt = ST_FLUSH; // RULE4
        end else if ((instr_r & `CIES_OP_BYTE_MASK) == `CIES_OP_COMPL_REG) begin
          zero_nxt = (inv_val == 8'h00); // RULE11
          if (dest_file) begin
            core_we    = 1'b1; // RULE5
            core_wdata = inv_val;
          end else begin
            accum_nxt = inv_val; // RULE5
          end
        end else if ((instr_r & `CIES_OP_CLR_REG_MASK) == `CIES_OP_CLR_REG) begin
          core_we    = 1'b1; // RULE6
          core_wdata = 8'h00;
          zero_nxt   = 1'b1;
        end else if ((instr_r & `CIES_OP_CLR_ACC_MASK) == `CIES_OP_CLR_ACC_VAL) begin
          accum_nxt = 8'h00; // RULE7
          zero_nxt  = 1'b1;
        end else if ((instr_r & `CIES_OP_BYTE_MASK) == `CIES_OP_DEC_REG) begin
          zero_nxt = (dec_val == 8'h00); // RULE8 RULE11
          if (dest_file) begin
            core_we    = 1'b1;
            core_wdata = dec_val;
          end else begin
            accum_nxt = dec_val;
          end
        end else if ((instr_r & `CIES_OP_BYTE_MASK) == `CIES_OP_DEC_SKIP) begin
          if (dest_file) begin
            core_we    = 1'b1; // RULE9
            core_wdata = dec_val;
          end else begin
            accum_nxt = dec_val; // RULE9
          end
          if (dec_val == 8'h00) begin
            skip_nxt  = 1'b1; // RULE10
            state_nxt = ST_FLUSH; // RULE12
          end
        end
      end
      ST_FLUSH: begin
        // Second cycle is a forced nop; a skip also steps over the discarded word
        state_nxt = ST_IDLE;
        if (skip_r) begin
          pc_nxt = pc_plus1; // RULE10 RULE12
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r          <= ST_IDLE;
      instr_r          <= 14'h0000;
      accum_r          <= `CIES_RST_ACCUM;
      pc_r             <= `CIES_RST_PC;
      pc_high_latch_r  <= `CIES_RST_PC_LATCH;
      file_addr_r      <= 7'h00;
      zero_r           <= `CIES_RST_ZERO;
      skip_r           <= 1'b0;
      sp_r             <= 3'd0;
    end else begin
      state_r <= state_nxt;
      accum_r <= accum_nxt;
      pc_r    <= pc_nxt;
      zero_r  <= zero_nxt;
      skip_r  <= skip_nxt;
      if (push_nxt) begin
        sp_r <= sp_r + 3'd1; // RULE2
      end
      // Software writes only land while idle, so they never collide with decode
      if (apb_wr) begin
        case (paddr)
          `CIES_ADDR_INSTR: begin
            instr_r <= pwdata[13:0];
            state_r <= ST_EXEC;
          end
          `CIES_ADDR_ACCUM: begin
            accum_r <= pwdata[7:0];
          end
          `CIES_ADDR_STATUS: begin
            zero_r <= pwdata[`CIES_ST_ZERO_BIT];
          end
          `CIES_ADDR_PC: begin
            pc_r <= pwdata[12:0];
          end
          `CIES_ADDR_PC_LATCH: begin
            pc_high_latch_r <= pwdata[4:0];
          end
          `CIES_ADDR_FILE_ADDR: begin
            file_addr_r <= pwdata[6:0];
          end
          default: begin
            file_addr_r <= file_addr_r;
          end
        endcase
      end
    end
  end

  // Return stack wraps after eight pushes, overwriting the oldest entry
  always @(posedge pclk) begin
    if (push_nxt) begin
      stack_mem[sp_r] <= pc_plus1; // RULE2
    end
  end

  // Watchdog: prescaler tick advances the counter; wrap drops the timeout flag
  assign presc_tick = (prescale_r == `CIES_WDOG_PRESC_MAX);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_r         <= 8'h00;
      watchdog_counter_r <= 8'h00;
      timeout_flag_r     <= `CIES_RST_TMOUT;
      powerdown_flag_r   <= `CIES_RST_PWRDN;
    end else if (wdog_clr) begin
      // Clear wins over a coincident timeout
      prescale_r         <= 8'h00; // RULE1
      watchdog_counter_r <= 8'h00; // RULE1
      timeout_flag_r     <= 1'b1; // RULE1
      powerdown_flag_r   <= 1'b1; // RULE1
    end else begin
      prescale_r <= prescale_r + 8'h01;
      if (presc_tick) begin
        watchdog_counter_r <= watchdog_counter_r + 8'h01;
        if (watchdog_counter_r == `CIES_WDOG_MAX) begin
          timeout_flag_r <= 1'b0;
        end
      end
    end
  end

  // Read data mux; unmapped addresses read zero
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `CIES_ADDR_INSTR:     rd_mux = {18'h00000, instr_r};
      `CIES_ADDR_ACCUM:     rd_mux = {24'h000000, accum_r};
      `CIES_ADDR_STATUS:    rd_mux = {27'h0000000, skip_r, busy, timeout_flag_r, powerdown_flag_r, zero_r};
      `CIES_ADDR_PC:        rd_mux = {19'h00000, pc_r};
      `CIES_ADDR_PC_LATCH:  rd_mux = {27'h0000000, pc_high_latch_r};
      `CIES_ADDR_STACK_TOP: rd_mux = {16'h0000, sp_r, stack_top};
      `CIES_ADDR_WDOG:      rd_mux = {16'h0000, prescale_r, watchdog_counter_r};
      `CIES_ADDR_FILE_ADDR: rd_mux = {25'h0000000, file_addr_r};
      `CIES_ADDR_FILE_DATA: rd_mux = {24'h000000, file_rdata};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // Word is latched at the end of the setup cycle, so reads keep zero wait states
  // while the data output still comes straight from a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      prdata <= rd_mux;
    end
  end

endmodule // cies_core

`default_nettype wire

//--- hdl/cies_consts.vh
// Constants for the instruction execution subset: offsets, encodings, reset values
`ifndef CIES_CONSTS_VH
`define CIES_CONSTS_VH

// Register byte addresses on the APB side
`define CIES_ADDR_INSTR      8'h00
`define CIES_ADDR_ACCUM      8'h04
`define CIES_ADDR_STATUS     8'h08
`define CIES_ADDR_PC         8'h0c
`define CIES_ADDR_PC_LATCH   8'h10
`define CIES_ADDR_STACK_TOP  8'h14
`define CIES_ADDR_WDOG       8'h18
`define CIES_ADDR_FILE_ADDR  8'h1c
`define CIES_ADDR_FILE_DATA  8'h20

// Status register field positions
`define CIES_ST_ZERO_BIT     0
`define CIES_ST_PWRDN_BIT    1
`define CIES_ST_TMOUT_BIT    2
`define CIES_ST_BUSY_BIT     3
`define CIES_ST_SKIP_BIT     4

// Reset values
`define CIES_RST_ACCUM       8'h00
`define CIES_RST_PC          13'h0000
`define CIES_RST_PC_LATCH    5'h00
`define CIES_RST_TMOUT       1'b1
`define CIES_RST_PWRDN       1'b1
`define CIES_RST_ZERO        1'b0

// Instruction encodings (14-bit words)
`define CIES_OP_WDOG_CLR     14'h0064
`define CIES_OP_CLR_ACC_MASK 14'h3f80
`define CIES_OP_CLR_ACC_VAL  14'h0100
`define CIES_OP_CALL_MASK    14'h3800
`define CIES_OP_CALL_VAL     14'h2000
`define CIES_OP_BYTE_MASK    14'h3f00
`define CIES_OP_COMPL_REG    14'h0900
`define CIES_OP_CLR_REG      14'h0180
`define CIES_OP_CLR_REG_MASK 14'h3f80
`define CIES_OP_DEC_REG      14'h0300
`define CIES_OP_DEC_SKIP     14'h0b00
`define CIES_DEST_BIT        7

// Widths and depths
`define CIES_FILE_DEPTH      128
`define CIES_STACK_DEPTH     8

// Watchdog prescaler terminal count (divide ratio minus one)
`define CIES_WDOG_PRESC_MAX  8'hff
`define CIES_WDOG_MAX        8'hff

`endif

//--- hdl/cies_regfile.v
// File register array: one synchronous write port, one asynchronous read port
`timescale 1ns/1ns
`default_nettype none
`include "cies_consts.vh"

module cies_regfile (
  input  wire       pclk,
  input  wire       we,
  input  wire [6:0] waddr,
  input  wire [7:0] wdata,
  input  wire [6:0] raddr,
  output wire [7:0] rdata
);

  reg [7:0] mem [0:`CIES_FILE_DEPTH-1];

  // No reset: contents are undefined after power-up, as in a real core
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];

endmodule // cies_regfile

`default_nettype wire

//--- verif/cies_core_sva.sv
// Checker for the APB side of the execution core
`timescale 1ns/1ns
`default_nettype none
module cies_core_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc     = psel && penable;
  wire bad     = (paddr > 8'h20) || (paddr[1:0] != 2'h0);
  wire issue   = acc && pready && pwrite && (paddr == 8'h00);
  wire call_tk = issue && (pwdata[13:11] == 3'h4);
  wire aclr_tk = issue && (pwdata[13:7] == 7'h02);
  read_no_wait_a: assert property (acc && !pwrite |-> pready) else $error("read stalled");
  err_decode_a: assert property (acc && pready |-> pslverr == bad) else $error("slave error wrong");
  err_phase_a: assert property (pslverr |-> acc && pready) else $error("slave error outside access");
  unmapped_zero_a: assert property (acc && !pwrite && bad |-> prdata == 32'h0) else $error("unmapped read not zero");
  wait_bound_a: assert property (acc && !pready |-> ##[1:3] pready) else $error("write wait too long");
  call_stall_a: assert property (call_tk ##1 (psel && !penable && pwrite) |=> !pready) else $error("call one cycle");
  call_done_a: assert property (call_tk ##1 (psel && !penable) ##1 acc |=> pready) else $error("call over two");
  accum_clear_a: assert property (aclr_tk ##1 (psel && !penable && pwrite) |=> pready) else $error("clear stalled");
endmodule // cies_core_sva
bind cies_core cies_core_sva cies_core_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

//--- verif/cies_core_tb.sv
// Testbench for the execution core subset
`timescale 1ns/1ns
`default_nettype none
`include "cies_consts.vh"
module cies_core_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [31:0] rv;
  logic        ev;
  cies_core cies_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Answer is read right after each rising edge, before the design's own updates from it land
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    ev = pslverr;
  endtask
  task automatic setf(input logic [6:0] f, input logic [7:0] v);
    apb(1'b1, `CIES_ADDR_FILE_ADDR, {25'h0, f});
    apb(1'b1, `CIES_ADDR_FILE_DATA, {24'h0, v});
  endtask
  // Trailing write to a read-only place waits out the whole instruction
  task automatic exec(input logic [13:0] op);
    apb(1'b1, `CIES_ADDR_INSTR, {18'h0, op});
    apb(1'b1, `CIES_ADDR_STACK_TOP, 32'h0);
  endtask
  task automatic byteop(input logic [13:0] op, input logic [7:0] init, res, input logic z, input logic [12:0] inc);
    apb(1'b1, `CIES_ADDR_STATUS, 32'h0);
    apb(1'b1, `CIES_ADDR_ACCUM, 32'h3c);
    apb(1'b1, `CIES_ADDR_PC, 32'h100);
    setf(op[6:0], init);
    exec(op);
    apb(1'b0, `CIES_ADDR_FILE_DATA, 32'h0);
    chk(rv, op[7] ? res : init);
    apb(1'b0, `CIES_ADDR_ACCUM, 32'h0);
    chk(rv, op[7] ? 32'h3c : res);
    apb(1'b0, `CIES_ADDR_STATUS, 32'h0);
    chk(rv, {31'h3, z});
    apb(1'b0, `CIES_ADDR_PC, 32'h0);
    chk(rv, 32'h100 + inc);
  endtask
  task automatic call(input logic [12:0] pc, input logic [4:0] hi, input logic [10:0] k);
    apb(1'b1, `CIES_ADDR_STATUS, 32'h1);
    apb(1'b1, `CIES_ADDR_PC, {19'h0, pc});
    apb(1'b1, `CIES_ADDR_PC_LATCH, {27'h0, hi});
    exec({3'h4, k});
    apb(1'b0, `CIES_ADDR_PC, 32'h0);
    chk(rv, {19'h0, hi[4:3], k});
    apb(1'b0, `CIES_ADDR_STACK_TOP, 32'h0);
    chk({19'h0, rv[12:0]}, {19'h0, pc + 13'h1});
    apb(1'b0, `CIES_ADDR_STATUS, 32'h0);
    chk(rv, 32'h7);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `CIES_ADDR_ACCUM, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, `CIES_ADDR_STATUS, 32'h0);
    chk(rv, 32'h6);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, ev}, 32'h1);
    chk(rv, 32'h0);
    byteop(14'h0905, 8'h5a, 8'ha5, 1'b0, 13'h1);
    byteop(14'h0986, 8'hff, 8'h00, 1'b1, 13'h1);
    byteop(14'h0185, 8'h77, 8'h00, 1'b1, 13'h1);
    byteop(14'h0307, 8'h01, 8'h00, 1'b1, 13'h1);
    byteop(14'h0388, 8'h00, 8'hff, 1'b0, 13'h1);
    byteop(14'h0b89, 8'h02, 8'h01, 1'b0, 13'h1);
    byteop(14'h0b0a, 8'h01, 8'h00, 1'b0, 13'h2);
    apb(1'b1, `CIES_ADDR_STATUS, 32'h0);
    apb(1'b1, `CIES_ADDR_ACCUM, 32'h33);
    exec(14'h0100);
    apb(1'b0, `CIES_ADDR_ACCUM, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, `CIES_ADDR_STATUS, 32'h0);
    chk(rv, 32'h7);
    call(13'h0123, 5'h18, 11'h7ff);
    call(13'h0abc, 5'h17, 11'h455);
    psel <= 1'b0;
    penable <= 1'b0;
    // Long idle lets the watchdog wrap once, so the clear has a dropped timeout flag to restore
    repeat (66500) @(posedge pclk);
    apb(1'b0, `CIES_ADDR_WDOG, 32'h0);
    chk({31'h0, rv[7:0] != 8'h0}, 32'h1);
    apb(1'b0, `CIES_ADDR_STATUS, 32'h0);
    chk(rv, 32'h3);
    apb(1'b1, `CIES_ADDR_STATUS, 32'h0);
    exec(14'h0064);
    apb(1'b0, `CIES_ADDR_WDOG, 32'h0);
    chk({16'h0, rv[15:12], 4'h0, rv[7:0]}, 32'h0);
    apb(1'b0, `CIES_ADDR_STATUS, 32'h0);
    chk(rv, 32'h6);
    end_sim();
  end
endmodule // cies_core_tb
`default_nettype wire
